//--- rtl/paf_pkg.sv
// Constants, register map and state types for the powerline front-end host controller.
package paf_pkg;

  // Clock and timing figures.
  localparam int CLK_MHZ = 100;
  localparam int RESET_NS = 100;
  localparam int RESET_CYC = (RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int SHDN_LEAD_NS = 100;
  localparam int SHDN_CYC = (SHDN_LEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] RESET_LOAD = CNT_W'(RESET_CYC);
  localparam logic [CNT_W-1:0] SHDN_LOAD = CNT_W'(SHDN_CYC);

  // Sample bus and serial port geometry.
  localparam int SAMPLE_W = 10;
  localparam int CFG_ADDR_W = 3;
  localparam int CFG_DATA_W = 16;
  localparam int FRAME_BITS = CFG_ADDR_W + CFG_DATA_W;
  localparam int BIT_CNT_W = 5;
  localparam logic [BIT_CNT_W-1:0] FRAME_LAST = BIT_CNT_W'(FRAME_BITS - 1);
  localparam logic [BIT_CNT_W-1:0] READ_LAST = BIT_CNT_W'(CFG_DATA_W - 1);
  localparam int HALF_W = 4;
  localparam logic [HALF_W-1:0] SCLK_HALF_LAST = 4'h3;

  // AXI4-Lite register map.
  localparam int AXI_ADDR_W = 4;
  localparam logic [AXI_ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [AXI_ADDR_W-1:0] REG_CFG_CMD = 4'h8;
  localparam logic [AXI_ADDR_W-1:0] REG_CFG_RDATA = 4'hc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register fields.
  localparam int CTRL_TX_GO = 0;
  localparam int CTRL_SHDN_EN = 1;
  localparam int CTRL_CARRIER = 2;
  localparam int CTRL_FREEZE = 3;
  localparam int CTRL_STANDBY = 4;
  localparam int CTRL_RESET = 5;
  localparam int CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET_VAL = 5'h00;

  // Status register fields.
  localparam int STAT_TX_ACTIVE = 0;
  localparam int STAT_RESETTING = 1;
  localparam int STAT_CFG_BUSY = 2;
  localparam int STAT_CFG_DONE = 3;
  localparam int STAT_RX_LSB = 16;

  // Configuration command fields.
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_READBACK = 3;
  localparam int CMD_DATA_LSB = 16;

  // Transmit session states, Gray along idle, on, tail.
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_ON = 2'b01,
    TX_TAIL = 2'b11
  } paf_tx_state_type;

  // Serial port states, Gray along the usual write-then-read path.
  typedef enum logic [2:0] {
    SP_IDLE = 3'b000,
    SP_SEL = 3'b001,
    SP_WSHIFT = 3'b011,
    SP_EXTRA = 3'b010,
    SP_DESEL = 3'b110,
    SP_RSHIFT = 3'b111,
    SP_DONE = 3'b101
  } paf_sp_state_type;

endpackage : paf_pkg

//--- rtl/paf_cfg_serial.sv
// Three-wire configuration port master: write frame, extra clock, optional read-back.
`timescale 1ns/10ps
module paf_cfg_serial (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Command side.
  input wire logic start,
  input wire logic read_back,
  input wire logic [paf_pkg::CFG_ADDR_W-1:0] addr,
  input wire logic [paf_pkg::CFG_DATA_W-1:0] wdata,
  output logic busy,
  output logic done,
  output logic [paf_pkg::CFG_DATA_W-1:0] rdata,
  // Serial pins.
  output logic sclk,
  output logic write_select,
  output logic sdata_out,
  output logic sdata_oe,
  input wire logic sdata_in
);

  paf_pkg::paf_sp_state_type state_r;
  logic [paf_pkg::HALF_W-1:0] half_r;
  logic phase_r;
  logic [paf_pkg::BIT_CNT_W-1:0] bit_r;
  logic [paf_pkg::FRAME_BITS-1:0] wsr_r;
  logic [paf_pkg::CFG_DATA_W-1:0] rsr_r;
  logic rb_r;
  logic tick;

  // One half of a serial clock period has elapsed.
  assign tick = (half_r == paf_pkg::SCLK_HALF_LAST);

  // Half-period timer runs only while a transfer is under way.
  always_ff @(posedge aclk) begin
    if (!aresetn || state_r == paf_pkg::SP_IDLE || tick) begin
      half_r <= '0;
    end else begin
      half_r <= half_r + 4'h1;
    end
  end

  // Sequencer: serial clock idles high, so each bit slot is a high half then a low half.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= paf_pkg::SP_IDLE;
      phase_r <= 1'b0;
      bit_r <= '0;
      wsr_r <= '0;
      rsr_r <= '0;
      rb_r <= 1'b0;
      sclk <= 1'b1;
      write_select <= 1'b0;
      sdata_out <= 1'b0;
      sdata_oe <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
    end else begin
      done <= 1'b0;
      case (state_r)
        paf_pkg::SP_IDLE: begin
          if (start) begin
            wsr_r <= {wdata, addr};
            rb_r <= read_back;
            sdata_out <= addr[0];
            sdata_oe <= 1'b1;
            write_select <= 1'b1;
            busy <= 1'b1;
            state_r <= paf_pkg::SP_SEL;
          end
        end
        paf_pkg::SP_SEL: begin
          if (tick) begin
            phase_r <= 1'b0;
            bit_r <= '0;
            state_r <= paf_pkg::SP_WSHIFT;
          end
        end
        paf_pkg::SP_WSHIFT: begin
          if (tick && !phase_r) begin
            sclk <= 1'b0;
            phase_r <= 1'b1;
          end else if (tick) begin
            sclk <= 1'b1;
            phase_r <= 1'b0;
            wsr_r <= wsr_r >> 1;
            sdata_out <= wsr_r[1];
            bit_r <= bit_r + 5'h01;
            if (bit_r == paf_pkg::FRAME_LAST) begin
              state_r <= paf_pkg::SP_EXTRA;
            end
          end
        end
        paf_pkg::SP_EXTRA: begin
          if (tick && !phase_r) begin
            sclk <= 1'b0;
            phase_r <= 1'b1;
          end else if (tick) begin
            sclk <= 1'b1;
            phase_r <= 1'b0;
            write_select <= 1'b0;
            sdata_oe <= 1'b0;
            sdata_out <= 1'b0;
            state_r <= rb_r ? paf_pkg::SP_DESEL : paf_pkg::SP_DONE;
          end
        end
        paf_pkg::SP_DESEL: begin
          if (tick) begin
            bit_r <= '0;
            state_r <= paf_pkg::SP_RSHIFT;
          end
        end
        paf_pkg::SP_RSHIFT: begin
          if (tick && !phase_r) begin
            sclk <= 1'b0;
            phase_r <= 1'b1;
          end else if (tick) begin
            sclk <= 1'b1;
            phase_r <= 1'b0;
            rsr_r <= {sdata_in, rsr_r[paf_pkg::CFG_DATA_W-1:1]};
            bit_r <= bit_r + 5'h01;
            if (bit_r == paf_pkg::READ_LAST) begin
              state_r <= paf_pkg::SP_DONE;
            end
          end
        end
        paf_pkg::SP_DONE: begin
          if (rb_r) begin
            rdata <= rsr_r;
          end
          done <= 1'b1;
          busy <= 1'b0;
          state_r <= paf_pkg::SP_IDLE;
        end
        default: begin
          state_r <= paf_pkg::SP_IDLE;
        end
      endcase
    end
  end

endmodule : paf_cfg_serial

//--- rtl/paf_host.sv
// Host controller for the powerline front end: AXI4-Lite registers, sample bus, control pins.
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
module paf_host (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address channel.
  input wire logic [paf_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data channel.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address channel.
  input wire logic [paf_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // User sample streams.
  input wire logic [paf_pkg::SAMPLE_W-1:0] tx_sample,
  output logic tx_take,
  output logic [paf_pkg::SAMPLE_W-1:0] rx_sample,
  output logic rx_valid,
  // Front-end clock, reset and mode pins.
  output logic afe_clk,
  output logic afe_reset_n,
  output logic standby,
  output logic transmit_enable,
  output logic bus_direction,
  output logic receiver_shutdown,
  output logic carrier_select,
  output logic gain_freeze,
  // Front-end sample bus.
  input wire logic [paf_pkg::SAMPLE_W-1:0] sample_bus_in,
  output logic [paf_pkg::SAMPLE_W-1:0] sample_bus_out,
  output logic sample_bus_oe,
  // Front-end configuration port.
  output logic cfg_sclk,
  output logic cfg_write_select,
  output logic cfg_serial_data_out,
  output logic cfg_serial_data_oe,
  input wire logic cfg_serial_data_in
);

  logic [paf_pkg::CTRL_W-1:0] ctrl_r;
  logic [paf_pkg::CNT_W-1:0] rst_cnt_r;
  logic [paf_pkg::CNT_W-1:0] tail_cnt_r;
  paf_pkg::paf_tx_state_type tx_state_r;
  logic [paf_pkg::AXI_ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_held_r;
  logic w_held_r;
  logic wr_fire;
  logic [31:0] wmask;
  logic cmd_start_r;
  logic cmd_rb_r;
  logic [paf_pkg::CFG_ADDR_W-1:0] cmd_addr_r;
  logic [paf_pkg::CFG_DATA_W-1:0] cmd_data_r;
  logic cfg_busy;
  logic cfg_done;
  logic [paf_pkg::CFG_DATA_W-1:0] cfg_rdata;
  logic cfg_done_flag_r;
  logic soft_reset;
  logic resetting;
  logic [31:0] status_word;

  // A register write happens once both address and data are held and no answer is pending.
  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign soft_reset = wr_fire && awaddr_r == paf_pkg::REG_CTRL && wstrb_r[0] && wdata_r[paf_pkg::CTRL_RESET];
  assign resetting = !afe_reset_n;

  // Status word gathered from live state.
  always_comb begin
    status_word = '0;
    status_word[paf_pkg::STAT_TX_ACTIVE] = (tx_state_r != paf_pkg::TX_IDLE);
    status_word[paf_pkg::STAT_RESETTING] = resetting;
    status_word[paf_pkg::STAT_CFG_BUSY] = cfg_busy;
    status_word[paf_pkg::STAT_CFG_DONE] = cfg_done_flag_r;
    status_word[paf_pkg::STAT_RX_LSB +: paf_pkg::SAMPLE_W] = rx_sample;
  end

  // Write address and data channels are taken independently and held until the write fires.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= paf_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r <= s_axi_awaddr;
        aw_held_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_held_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_r == paf_pkg::REG_CTRL || awaddr_r == paf_pkg::REG_STATUS ||
            awaddr_r == paf_pkg::REG_CFG_CMD) begin
          s_axi_bresp <= paf_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= paf_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Control register: transmit request, shutdown mode, carrier select, freeze and standby.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= paf_pkg::CTRL_RESET_VAL;
    end else if (wr_fire && awaddr_r == paf_pkg::REG_CTRL) begin
      ctrl_r <= (ctrl_r & ~wmask[paf_pkg::CTRL_W-1:0]) | (wdata_r[paf_pkg::CTRL_W-1:0] & wmask[paf_pkg::CTRL_W-1:0]);
    end
  end

  // Configuration command register; a write while the port is busy is ignored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_start_r <= 1'b0;
      cmd_rb_r <= 1'b0;
      cmd_addr_r <= '0;
      cmd_data_r <= '0;
    end else begin
      cmd_start_r <= 1'b0;
      if (wr_fire && awaddr_r == paf_pkg::REG_CFG_CMD && wstrb_r[0] && !cfg_busy && !cmd_start_r) begin
        cmd_start_r <= 1'b1;
        cmd_rb_r <= wdata_r[paf_pkg::CMD_READBACK];
        cmd_addr_r <= wdata_r[paf_pkg::CMD_ADDR_LSB +: paf_pkg::CFG_ADDR_W];
        cmd_data_r <= wdata_r[paf_pkg::CMD_DATA_LSB +: paf_pkg::CFG_DATA_W];
      end
    end
  end

  // Sticky completion flag, cleared by writing one to it; a new completion wins over the clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_done_flag_r <= 1'b0;
    end else if (cfg_done) begin
      cfg_done_flag_r <= 1'b1;
    end else if (wr_fire && awaddr_r == paf_pkg::REG_STATUS && wstrb_r[0] && wdata_r[paf_pkg::STAT_CFG_DONE]) begin
      cfg_done_flag_r <= 1'b0;
    end
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= paf_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= paf_pkg::RESP_OKAY;
      if (s_axi_araddr == paf_pkg::REG_CTRL) begin
        s_axi_rdata <= {27'h0000000, ctrl_r};
      end else if (s_axi_araddr == paf_pkg::REG_STATUS) begin
        s_axi_rdata <= status_word;
      end else if (s_axi_araddr == paf_pkg::REG_CFG_CMD) begin
        s_axi_rdata <= {cmd_data_r, 12'h000, cmd_rb_r, cmd_addr_r};
      end else if (s_axi_araddr == paf_pkg::REG_CFG_RDATA) begin
        s_axi_rdata <= {16'h0000, cfg_rdata};
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= paf_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Front-end system clock: aclk divided by two, running free through the front-end reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      afe_clk <= 1'b0;
    end else begin
      afe_clk <= ~afe_clk;
    end
  end

  // Front-end reset pulse after power-up and on software request, held at least 100ns.
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      rst_cnt_r <= paf_pkg::RESET_LOAD;
      afe_reset_n <= 1'b0;
    end else if (rst_cnt_r != '0) begin
      rst_cnt_r <= rst_cnt_r - 8'h01;
      afe_reset_n <= 1'b0;
    end else begin
      afe_reset_n <= 1'b1;
    end
  end

  // Mode pins follow the control register; carrier select and gain freeze are quiet while the front end is in reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      standby <= 1'b0;
      carrier_select <= 1'b0;
      gain_freeze <= 1'b0;
    end else begin
      standby <= ctrl_r[paf_pkg::CTRL_STANDBY];
      carrier_select <= ctrl_r[paf_pkg::CTRL_CARRIER] && !resetting;
      gain_freeze <= ctrl_r[paf_pkg::CTRL_FREEZE] && !resetting;
    end
  end

  // Transmit session: enable, direction and shutdown move together; a tail keeps shutdown high
  // for the lead time before transmit enable falls.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_r <= paf_pkg::TX_IDLE;
      tail_cnt_r <= '0;
      transmit_enable <= 1'b0;
      bus_direction <= 1'b0;
      receiver_shutdown <= 1'b0;
    end else begin
      case (tx_state_r)
        paf_pkg::TX_IDLE: begin
          if (ctrl_r[paf_pkg::CTRL_TX_GO] && !resetting && !ctrl_r[paf_pkg::CTRL_STANDBY]) begin
            tx_state_r <= paf_pkg::TX_ON;
            transmit_enable <= 1'b1;
            bus_direction <= 1'b1;
            receiver_shutdown <= ctrl_r[paf_pkg::CTRL_SHDN_EN];
          end
        end
        paf_pkg::TX_ON: begin
          if (!ctrl_r[paf_pkg::CTRL_TX_GO] || resetting) begin
            if (receiver_shutdown && !resetting) begin
              tx_state_r <= paf_pkg::TX_TAIL;
              tail_cnt_r <= paf_pkg::SHDN_LOAD;
            end else begin
              tx_state_r <= paf_pkg::TX_IDLE;
              transmit_enable <= 1'b0;
              bus_direction <= 1'b0;
              receiver_shutdown <= 1'b0;
            end
          end
        end
        paf_pkg::TX_TAIL: begin
          tail_cnt_r <= tail_cnt_r - 8'h01;
          if (tail_cnt_r == 8'h01 || resetting) begin
            tx_state_r <= paf_pkg::TX_IDLE;
            transmit_enable <= 1'b0;
            bus_direction <= 1'b0;
            receiver_shutdown <= 1'b0;
          end
        end
        default: begin
          tx_state_r <= paf_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // Sample bus: one sample each front-end clock period, launched and captured as it rises.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_bus_out <= '0;
      sample_bus_oe <= 1'b0;
      tx_take <= 1'b0;
      rx_sample <= '0;
      rx_valid <= 1'b0;
    end else begin
      sample_bus_oe <= bus_direction;
      tx_take <= 1'b0;
      rx_valid <= 1'b0;
      if (!afe_clk && bus_direction) begin
        sample_bus_out <= tx_sample;
        tx_take <= 1'b1;
      end else if (!afe_clk && !bus_direction && !sample_bus_oe) begin
        rx_sample <= sample_bus_in;
        rx_valid <= 1'b1;
      end
    end
  end

  // Serial configuration port engine.
  paf_cfg_serial u_cfg (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(cmd_start_r),
    .read_back(cmd_rb_r),
    .addr(cmd_addr_r),
    .wdata(cmd_data_r),
    .busy(cfg_busy),
    .done(cfg_done),
    .rdata(cfg_rdata),
    .sclk(cfg_sclk),
    .write_select(cfg_write_select),
    .sdata_out(cfg_serial_data_out),
    .sdata_oe(cfg_serial_data_oe),
    .sdata_in(cfg_serial_data_in)
  );

endmodule : paf_host

//--- verif/paf_afe_model.sv
// Behavioural model of the front end's converters and serial port.
`timescale 1ns/10ps
module paf_afe_model (
  // Clocks and mode pins from the host.
  input wire logic afe_clk,
  input wire logic cfg_sclk,
  input wire logic cfg_write_select,
  input wire logic bus_direction,
  input wire logic transmit_enable,
  // Resolved data lines.
  input wire logic cfg_serial_data_in,
  input wire logic [9:0] sample_bus_in,
  // Model drives and observations.
  output logic m_sd,
  output logic [9:0] m_bus,
  output logic [9:0] dac_last,
  output logic [15:0] last_wr
);
  logic [18:0] hold_r;
  logic [15:0] out_r;
  logic [15:0] regs_r [0:7];
  logic [9:0] adc_r = 10'h0;
  logic [4:0] cnt_r = 5'h0;
  logic [2:0] adr_r = 3'h0;

  // The read line starts low before any read.
  initial m_sd = 1'b0;

  // ADC samples step at each converter clock fall; host samples reach the DAC only in transmit.
  always @(negedge afe_clk) begin
    adc_r <= adc_r + 10'h1;
    if (transmit_enable && bus_direction) dac_last <= sample_bus_in;
  end

  // Toward the host the model drives ADC data, otherwise the inverse so stale values never match.
  assign m_bus = bus_direction ? ~adc_r : adc_r;

  // Entering write mode restarts the bit count; the released read line flips so stale bits never match.
  always @(posedge cfg_write_select) begin
    cnt_r <= 5'h0;
    m_sd <= ~m_sd;
  end

  // Bits enter LSB first on falling serial clock; the extra clock commits the holding buffer.
  always @(negedge cfg_sclk) begin
    if (cfg_write_select && cnt_r < 5'h13) begin
      hold_r <= {cfg_serial_data_in, hold_r[18:1]};
      cnt_r <= cnt_r + 5'h1;
    end else if (cfg_write_select) begin
      regs_r[hold_r[2:0]] <= hold_r[18:3];
      adr_r <= hold_r[2:0];
      last_wr <= hold_r[18:3];
    end else begin
      m_sd <= out_r[0];
      out_r <= {~out_r[0], out_r[15:1]};
    end
  end

  // Read mode starts from the register just written.
  always @(negedge cfg_write_select) out_r <= regs_r[adr_r];
endmodule : paf_afe_model

//--- verif/paf_host_monitor.sv
// Assertions on the host controller's front-end pins.
`timescale 1ns/10ps
module paf_host_monitor (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Front-end mode and sample pins.
  input wire logic afe_clk,
  input wire logic afe_reset_n,
  input wire logic transmit_enable,
  input wire logic bus_direction,
  input wire logic receiver_shutdown,
  input wire logic sample_bus_oe,
  input wire logic tx_take,
  input wire logic rx_valid,
  // Serial port pins.
  input wire logic cfg_sclk,
  input wire logic cfg_write_select,
  input wire logic cfg_serial_data_out,
  input wire logic cfg_serial_data_oe
);
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_tx_pair: assert property (transmit_enable == bus_direction)
    else $error("enable and direction differ");
  chk_dir_oe: assert property (!bus_direction && !$past(bus_direction) |-> !sample_bus_oe)
    else $error("sample bus driven in receive");
  chk_rx_dir: assert property (rx_valid |-> !$past(bus_direction) && !$past(sample_bus_oe))
    else $error("receive sample while transmitting");
  chk_take_dir: assert property (tx_take |-> $past(bus_direction) && $past(transmit_enable))
    else $error("sample taken outside transmit");
  chk_shdn_tx: assert property (receiver_shutdown |-> transmit_enable)
    else $error("shutdown without transmit");
  chk_shdn_lead: assert property ($fell(transmit_enable) && $past(receiver_shutdown) |->
    $past(receiver_shutdown, 10))
    else $error("shutdown lead too short");
  chk_clk_half: assert property ($past(aresetn) |-> afe_clk != $past(afe_clk))
    else $error("converter clock stalled");
  chk_rst_len: assert property ($rose(afe_reset_n) |-> !$past(afe_reset_n, 10))
    else $error("front-end reset too short");
  chk_sd_write: assert property (cfg_serial_data_oe |-> cfg_write_select)
    else $error("data driven in read mode");
  chk_sd_stable: assert property ($fell(cfg_sclk) && cfg_serial_data_oe |-> $stable(cfg_serial_data_out))
    else $error("data moved at sampling edge");
  chk_wsel_frame: assert property ($rose(cfg_write_select) |-> cfg_sclk [*8] ##1 !cfg_sclk)
    else $error("frame start mistimed");
endmodule : paf_host_monitor

bind paf_host paf_host_monitor i_paf_host_monitor (.*);

//--- verif/paf_host_tb.sv
// Self-checking testbench for the front-end host controller.
`timescale 1ns/10ps
module paf_host_tb;
  // Master drives, design outputs and resolved lines.
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [9:0] tx_sample = 10'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_take, rx_valid, afe_clk;
  logic afe_reset_n, standby, transmit_enable, bus_direction, receiver_shutdown, carrier_select, gain_freeze;
  logic sample_bus_oe, cfg_sclk, cfg_write_select, cfg_serial_data_out, cfg_serial_data_oe, m_sd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic [9:0] rx_sample, sample_bus_out, m_bus, dac_last;
  logic [15:0] last_wr;
  int miscompares = 0;
  int samples_checked = 0;
  wire logic [9:0] sample_bus_in = sample_bus_oe ? sample_bus_out : m_bus;
  wire logic cfg_serial_data_in = cfg_serial_data_oe ? cfg_serial_data_out : m_sd;

  paf_host i_paf_host (.*);
  paf_afe_model i_paf_afe_model (.*);

  // The system clock.
  initial begin
    forever #5 aclk = ~aclk;
  end

  // Compares one result against its expected value.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // Prints the verdict and stops.
  task automatic conclude;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // A wait that used its whole bound ends the run.
  task automatic lim(input int n);
    if (n >= 400) begin
      miscompares++;
      conclude();
    end
  endtask : lim

  // One write; address and data are offered together and released once taken.
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    lim(n);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw

  // One read; data and response are taken at the edge that shows them.
  task automatic axr(input logic [3:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    lim(n);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr

  // Reset, then the power-up front-end reset must last its minimum.
  task automatic t_reset;
    int n;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (n = 0; n < 400 && afe_reset_n !== 1'b1; n++) @(posedge aclk);
    lim(n);
    chk(32'(n >= 10), 32'h1);
  endtask : t_reset

  // Mode pins follow the control register; a write to the read-only read-data register is refused.
  task automatic t_regs;
    int n;
    axw(paf_pkg::REG_CTRL, 32'h1c);
    axr(paf_pkg::REG_CTRL);
    chk(rd, 32'h1c);
    chk(32'({standby, gain_freeze, carrier_select}), 32'h7);
    axw(4'hc, 32'h0);
    chk(32'(rsp), 32'(paf_pkg::RESP_SLVERR));
    axw(paf_pkg::REG_CTRL, 32'h0);
    @(negedge aclk);
    chk(32'({standby, gain_freeze, carrier_select}), 32'h0);
    axw(paf_pkg::REG_CTRL, 32'h20);
    chk(32'(afe_reset_n), 32'h0);
    for (n = 0; n < 400 && afe_reset_n !== 1'b1; n++) @(posedge aclk);
    lim(n);
    chk(32'(n >= 10), 32'h1);
  endtask : t_regs

  // Transmit with receiver shutdown, then the tail drops everything.
  task automatic t_tx;
    tx_sample <= 10'h2a5;
    axw(paf_pkg::REG_CTRL, 32'h3);
    repeat (10) @(posedge aclk);
    chk(32'({transmit_enable, bus_direction, receiver_shutdown, sample_bus_oe}), 32'hf);
    chk(32'(dac_last), 32'h2a5);
    axw(paf_pkg::REG_CTRL, 32'h0);
    repeat (5) @(posedge aclk);
    chk(32'({transmit_enable, receiver_shutdown}), 32'h3);
    repeat (9) @(posedge aclk);
    chk(32'({transmit_enable, receiver_shutdown, sample_bus_oe}), 32'h0);
  endtask : t_tx

  // Received samples arrive one per converter clock.
  task automatic t_rx;
    int n;
    int k;
    logic [9:0] v;
    for (k = 0; k < 2; k++) begin
      v = rx_sample;
      for (n = 0; n < 400; n++) begin
        @(posedge aclk);
        if (rx_valid === 1'b1) break;
      end
      lim(n);
    end
    chk(32'(rx_sample), 32'(v + 10'h1));
  endtask : t_rx

  // Write then read back front-end registers 0 to 5.
  task automatic t_cfg;
    int i;
    int n;
    logic [15:0] d;
    for (i = 0; i < 6; i++) begin
      d = 16'h5a3c + 16'(i) * 16'h1357;
      axw(paf_pkg::REG_STATUS, 32'h8);
      axw(paf_pkg::REG_CFG_CMD, {d, 12'h0, 1'b1, i[2:0]});
      for (n = 0; n < 400; n++) begin
        axr(paf_pkg::REG_STATUS);
        if (rd[paf_pkg::STAT_CFG_DONE] === 1'b1) break;
      end
      lim(n);
      chk(32'(last_wr), 32'(d));
      axr(paf_pkg::REG_CFG_RDATA);
      chk(32'(rd[15:0]), 32'(d));
    end
  endtask : t_cfg

  // Main sequence.
  initial begin
    t_reset();
    t_regs();
    t_tx();
    t_rx();
    t_cfg();
    conclude();
  end
endmodule : paf_host_tb
